/* shared/pvirq_map.svh */
/*
 Constants of the prioritized vectored interrupt controller: register offsets,
 field positions, reset values and vector layout.
 Assumes it is included by the package and by the controller module.
*/
// What this block does
// - Fifteen request lines, each enabled and leveled
// - Upper priority bits 7..0 select lines 14..7
// - Software flag writes act like hardware
// - Individual enable gates; global enable clear blocks all
// - Only high level preempts low; none preempts high
// - High level request wins over low level
// - Fixed order within level, line 0 first
// - Sample at instruction start, evaluate next start
// - No call while equal or higher level active
// - No call after exit or enable/priority write
// - Blocked requests are not remembered
// - Each line vectors to its fixed address
// - Lines 0..6 default to external pins, timers and serial units
// - Core pushes PC only, then loads vector
// - Serial flags never cleared; external only if edge
// - Interrupt exit ends level; plain return does not
// - Trigger type selects low level or falling edge
// - Pin levels inverted before entering request flags
// - Edge flag cleared when routine is called
// - Call takes two core machine cycles
// - Blocked delay bounded by core instruction lengths
// - Global enable is bit 7 of lower enable
// - Timer overflow flags cleared on vectoring
`ifndef PVIRQ_MAP_SVH
`define PVIRQ_MAP_SVH
// ==========================================================
// Register byte offsets
`define PVIRQ_OFF_EN_LO 8'h00
`define PVIRQ_OFF_EN_HI 8'h04
`define PVIRQ_OFF_PR_LO 8'h08
`define PVIRQ_OFF_PR_HI 8'h0C
`define PVIRQ_OFF_TCTL 8'h10
`define PVIRQ_OFF_STAT 8'h14
// ==========================================================
// Field positions
`define PVIRQ_GIE_BIT 7
`define PVIRQ_TF1_BIT 7
`define PVIRQ_TF0_BIT 5
`define PVIRQ_IE1_BIT 3
`define PVIRQ_IT1_BIT 2
`define PVIRQ_IE0_BIT 1
`define PVIRQ_IT0_BIT 0
// ==========================================================
// Reset values and vector layout
`define PVIRQ_REG_RST 8'h00
`define PVIRQ_PIN_RST 3'h7
`define PVIRQ_VEC_BASE 16'h0003
`define PVIRQ_VEC_ODD 16'h0005
`define PVIRQ_VEC_STRIDE 16'h0010
`define PVIRQ_MAX_LINES 15
`define PVIRQ_RESP_OK 2'h0
`define PVIRQ_RESP_ERR 2'h2
`endif

/* shared/pvirq_pkg.sv */
/*
 Types of the prioritized vectored interrupt controller.
 Assumes pvirq_map.svh is on the include path.
*/
`include "pvirq_map.svh"
package pvirq_pkg;
	typedef enum logic [0:0] {PV_IDLE, PV_CALL} pvirq_fsm_t;

	// Instruction events from the core
	typedef struct packed {
		logic start;
		logic is_exit;
	} pvirq_core_t;

	// Vector call request to the core
	typedef struct packed {
		logic req;
		logic [15:0] addr;
		logic [3:0] src;
	} pvirq_call_t;

	typedef struct packed {
		logic [7:0] en_lo;
		logic [7:0] en_hi;
		logic [7:0] pr_lo;
		logic [7:0] pr_hi;
		logic it0;
		logic it1;
		logic ie0;
		logic ie1;
		logic tf0;
		logic tf1;
		logic [2:0] p0_sync;
		logic [2:0] p1_sync;
		logic p0_lvl;
		logic p1_lvl;
		logic [14:0] sample;
		logic blk;
		logic ip_hi;
		logic ip_lo;
		logic cur_hi;
		pvirq_fsm_t fsm;
		pvirq_call_t call;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [7:0] wdata;
		logic wlane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pvirq_state_t;
endpackage

/* hdl/pvirq_top.sv */
/*
 Two-level vectored interrupt controller with AXI4-Lite register access.
 Assumes a core that pulses instruction start and interrupt exit, and that
 acknowledges a vector call once it performs it. Peripherals above line 3
 own their flags and drive them as levels.
*/
`include "pvirq_map.svh"
module pvirq_top #(
	parameter int NUM_LINES = 15
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pvirq_pkg::pvirq_core_t core_ev,
	input wire logic vec_ack,
	output pvirq_pkg::pvirq_call_t vec_call,
	input wire logic ext0_pin_n,
	input wire logic ext1_pin_n,
	input wire logic timer0_ovf_set,
	input wire logic timer1_ovf_set,
	input wire logic [14:4] periph_req
);
	if (NUM_LINES < 1 || NUM_LINES > `PVIRQ_MAX_LINES)
	begin : g_bad_lines
		$error("NUM_LINES must be 1 to 15");
	end

	pvirq_pkg::pvirq_state_t st_ff;
	pvirq_pkg::pvirq_state_t nxt_st;
	logic [14:0] live_mask;
	logic [14:0] flags;
	logic [14:0] enab;
	logic [14:0] prio;
	logic [14:0] cand;
	logic [14:0] cand_hi;
	logic win_found;
	logic win_hi;
	logic [3:0] win_src;
	logic blocked;
	logic p0_stable;
	logic p1_stable;
	logic p0_fall;
	logic p1_fall;
	logic wr_do;
	logic rd_do;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Vector of line i: even lines at base, odd lines five bytes later
	function automatic logic [15:0] vec_of(input logic [3:0] src);
		logic [15:0] v;
		v = `PVIRQ_VEC_BASE + `PVIRQ_VEC_STRIDE * {13'h0000, src[3:1]};
		if (src[0])
			v = v + `PVIRQ_VEC_ODD;
		return v;
	endfunction

	// ==========================================================
	// Request flags and priority pick
	genvar gi;
	generate
		for (gi = 0; gi < 15; gi++)
		begin : g_line
			assign live_mask[gi] = (gi < NUM_LINES);
		end
	endgenerate

	// Lines 0 and 2 are the external pin flags, 1 and 3 the timer flags, 4..14 come from their peripherals
	assign flags[0] = st_ff.it0 ? st_ff.ie0 : ~st_ff.p0_lvl;
	assign flags[1] = st_ff.tf0;
	assign flags[2] = st_ff.it1 ? st_ff.ie1 : ~st_ff.p1_lvl;
	assign flags[3] = st_ff.tf1;
	assign flags[14:4] = periph_req;

	assign enab = {st_ff.en_hi, st_ff.en_lo[6:0]} & live_mask;
	assign prio = {st_ff.pr_hi, st_ff.pr_lo[6:0]};
	assign cand = st_ff.en_lo[`PVIRQ_GIE_BIT] ? (st_ff.sample & enab) : 15'h0000;
	assign cand_hi = cand & prio;

	always_comb
	begin
		win_found = 1'b0;
		win_hi = 1'b0;
		win_src = 4'h0;
		// Downward scan leaves the lowest index: fixed order within level
		for (int i = 14; i >= 0; i--)
		begin
			if (cand_hi[i])
			begin
				win_found = 1'b1;
				win_hi = 1'b1;
				win_src = 4'(i);
			end
		end
		if (!win_hi)
		begin
			for (int i = 14; i >= 0; i--)
			begin
				if (cand[i])
				begin
					win_found = 1'b1;
					win_src = 4'(i);
				end
			end
		end
	end

	// Equal or higher level in progress, or an exit or config write just ran
	assign blocked = st_ff.ip_hi || (st_ff.ip_lo && !win_hi) || st_ff.blk
		|| (st_ff.fsm != pvirq_pkg::PV_IDLE);

	// ==========================================================
	// Pin capture: a change counts once stages two and three agree
	assign p0_stable = (st_ff.p0_sync[1] == st_ff.p0_sync[2]);
	assign p1_stable = (st_ff.p1_sync[1] == st_ff.p1_sync[2]);
	assign p0_fall = p0_stable && !st_ff.p0_sync[2] && st_ff.p0_lvl;
	assign p1_fall = p1_stable && !st_ff.p1_sync[2] && st_ff.p1_lvl;

	// ==========================================================
	// Register bus
	assign wr_do = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign rd_do = s_axi_arvalid && st_ff.arready;

	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`PVIRQ_OFF_EN_LO: rd_byte = st_ff.en_lo;
			`PVIRQ_OFF_EN_HI: rd_byte = st_ff.en_hi;
			`PVIRQ_OFF_PR_LO: rd_byte = {1'b0, st_ff.pr_lo[6:0]};
			`PVIRQ_OFF_PR_HI: rd_byte = st_ff.pr_hi;
			`PVIRQ_OFF_TCTL: rd_byte = {st_ff.tf1, 1'b0, st_ff.tf0, 1'b0,
				st_ff.ie1, st_ff.it1, st_ff.ie0, st_ff.it0};
			`PVIRQ_OFF_STAT: rd_byte = {st_ff.ip_hi, st_ff.ip_lo, st_ff.cur_hi,
				st_ff.call.req, st_ff.call.src};
			default:
			begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_st = st_ff;
		// Pins are idle high; flops see them through three stages
		nxt_st.p0_sync = {st_ff.p0_sync[1:0], ext0_pin_n};
		nxt_st.p1_sync = {st_ff.p1_sync[1:0], ext1_pin_n};
		if (p0_stable)
			nxt_st.p0_lvl = st_ff.p0_sync[2];
		if (p1_stable)
			nxt_st.p1_lvl = st_ff.p1_sync[2];

		// Bus handshakes
		nxt_st.awready = !st_ff.aw_got && !s_axi_awvalid ? 1'b1 : !st_ff.aw_got
			&& !(s_axi_awvalid && st_ff.awready);
		if (s_axi_awvalid && st_ff.awready)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		nxt_st.wready = !st_ff.w_got && !(s_axi_wvalid && st_ff.wready);
		if (s_axi_wvalid && st_ff.wready)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata[7:0];
			nxt_st.wlane0 = s_axi_wstrb[0];
		end
		if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end
		nxt_st.arready = !st_ff.rvalid && !rd_do;
		if (rd_do)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = {24'h000000, rd_byte};
			nxt_st.rresp = rd_hit ? `PVIRQ_RESP_OK : `PVIRQ_RESP_ERR;
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// Exit or config write blocks exactly the next poll
		if (core_ev.start)
			nxt_st.blk = 1'b0;

		if (wr_do)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = `PVIRQ_RESP_OK;
			case (st_ff.awaddr)
				`PVIRQ_OFF_EN_LO, `PVIRQ_OFF_EN_HI, `PVIRQ_OFF_PR_LO, `PVIRQ_OFF_PR_HI:
					nxt_st.blk = 1'b1;
				`PVIRQ_OFF_TCTL, `PVIRQ_OFF_STAT: ;
				default: nxt_st.bresp = `PVIRQ_RESP_ERR;
			endcase
			if (st_ff.wlane0)
			begin
				case (st_ff.awaddr)
					`PVIRQ_OFF_EN_LO: nxt_st.en_lo = st_ff.wdata;
					`PVIRQ_OFF_EN_HI: nxt_st.en_hi = st_ff.wdata;
					`PVIRQ_OFF_PR_LO: nxt_st.pr_lo = {1'b0, st_ff.wdata[6:0]};
					`PVIRQ_OFF_PR_HI: nxt_st.pr_hi = st_ff.wdata;
					`PVIRQ_OFF_TCTL:
					begin
						// Writes move the flags as hardware would
						nxt_st.tf1 = st_ff.wdata[`PVIRQ_TF1_BIT];
						nxt_st.tf0 = st_ff.wdata[`PVIRQ_TF0_BIT];
						nxt_st.ie1 = st_ff.wdata[`PVIRQ_IE1_BIT];
						nxt_st.it1 = st_ff.wdata[`PVIRQ_IT1_BIT];
						nxt_st.ie0 = st_ff.wdata[`PVIRQ_IE0_BIT];
						nxt_st.it0 = st_ff.wdata[`PVIRQ_IT0_BIT];
					end
					default: ;
				endcase
			end
		end
		if (core_ev.is_exit)
		begin
			nxt_st.blk = 1'b1;
			// Only the top active level ends; a plain return never reaches here
			if (st_ff.ip_hi)
				nxt_st.ip_hi = 1'b0;
			else
				nxt_st.ip_lo = 1'b0;
		end

		// Poll last sample, then take a fresh one; nothing else is kept
		if (core_ev.start)
		begin
			nxt_st.sample = flags & live_mask;
			if (win_found && !blocked)
			begin
				nxt_st.fsm = pvirq_pkg::PV_CALL;
				nxt_st.call.req = 1'b1;
				nxt_st.call.src = win_src;
				nxt_st.call.addr = vec_of(win_src);
				nxt_st.cur_hi = win_hi;
			end
		end

		// The core pushes PC and jumps; this block ends the request, marks the level active and clears a timer flag or an edge-mode pin flag
		case (st_ff.fsm)
			pvirq_pkg::PV_IDLE: ;
			pvirq_pkg::PV_CALL:
			begin
				if (vec_ack)
				begin
					nxt_st.fsm = pvirq_pkg::PV_IDLE;
					nxt_st.call.req = 1'b0;
					if (st_ff.cur_hi)
						nxt_st.ip_hi = 1'b1;
					else
						nxt_st.ip_lo = 1'b1;
					case (st_ff.call.src)
						4'h0: if (st_ff.it0) nxt_st.ie0 = 1'b0;
						4'h1: nxt_st.tf0 = 1'b0;
						4'h2: if (st_ff.it1) nxt_st.ie1 = 1'b0;
						4'h3: nxt_st.tf1 = 1'b0;
						default: ;
					endcase
				end
			end
			default: nxt_st.fsm = pvirq_pkg::PV_IDLE;
		endcase

		// Hardware set events win over any clear in the same cycle
		if (timer0_ovf_set)
			nxt_st.tf0 = 1'b1;
		if (timer1_ovf_set)
			nxt_st.tf1 = 1'b1;
		if (p0_fall && st_ff.it0)
			nxt_st.ie0 = 1'b1;
		if (p1_fall && st_ff.it1)
			nxt_st.ie1 = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.p0_sync <= `PVIRQ_PIN_RST;
			st_ff.p1_sync <= `PVIRQ_PIN_RST;
			st_ff.p0_lvl <= 1'b1;
			st_ff.p1_lvl <= 1'b1;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
			st_ff.fsm <= pvirq_pkg::PV_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign vec_call = st_ff.call;

	// ==========================================================
	// Checks
	property p_global_gate;
		@(posedge core_clk) disable iff (rst)
		(core_ev.start && !st_ff.en_lo[7] && st_ff.fsm == pvirq_pkg::PV_IDLE) |=> !vec_call.req;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("call raised with global enable clear");

	property p_block_after_exit;
		@(posedge core_clk) disable iff (rst)
		(st_ff.blk && core_ev.start && !vec_call.req) |=> !vec_call.req;
	endproperty
	a_block_after_exit: assert property (p_block_after_exit)
		else $error("call raised right after exit or config write");

	property p_high_not_preempted;
		@(posedge core_clk) disable iff (rst)
		(st_ff.ip_hi && !vec_call.req && !core_ev.is_exit) |=> !vec_call.req;
	endproperty
	a_high_not_preempted: assert property (p_high_not_preempted)
		else $error("high level routine preempted");

	property p_low_only_by_high;
		@(posedge core_clk) disable iff (rst)
		$rose(vec_call.req) && $past(st_ff.ip_lo) |-> st_ff.cur_hi;
	endproperty
	a_low_only_by_high: assert property (p_low_only_by_high)
		else $error("low level routine preempted by low request");

	property p_vector_addr;
		@(posedge core_clk) disable iff (rst)
		vec_call.req |-> vec_call.addr[3:0] == (vec_call.src[0] ? 4'h8 : 4'h3)
			&& vec_call.addr[15:4] == {9'h000, vec_call.src[3:1]};
	endproperty
	a_vector_addr: assert property (p_vector_addr)
		else $error("vector address does not match source");

	property p_call_holds;
		@(posedge core_clk) disable iff (rst)
		(vec_call.req && !vec_ack) |=> vec_call.req && $stable(vec_call.addr);
	endproperty
	a_call_holds: assert property (p_call_holds)
		else $error("call request dropped before acknowledge");

	property p_edge_flag_clear;
		@(posedge core_clk) disable iff (rst)
		(vec_call.req && vec_ack && vec_call.src == 4'h0 && st_ff.it0 && !p0_fall)
			|=> !st_ff.ie0;
	endproperty
	a_edge_flag_clear: assert property (p_edge_flag_clear)
		else $error("edge flag not cleared on call");

	property p_timer_flag_clear;
		@(posedge core_clk) disable iff (rst)
		(vec_call.req && vec_ack && vec_call.src == 4'h1 && !timer0_ovf_set && !wr_do)
			|=> !st_ff.tf0;
	endproperty
	a_timer_flag_clear: assert property (p_timer_flag_clear)
		else $error("timer flag not cleared on call");

	property p_exit_ends_level;
		@(posedge core_clk) disable iff (rst)
		(core_ev.is_exit && st_ff.ip_hi && !vec_ack) |=> !st_ff.ip_hi ##1 !st_ff.ip_hi;
	endproperty
	a_exit_ends_level: assert property (p_exit_ends_level)
		else $error("exit did not end the high level");
endmodule

/* tb/pvirq_core_model.sv */
/*
 Behavioural core for the interrupt controller: an instruction start every
 four cycles, interrupt exits on request, and acknowledge of vector calls.
 Assumes the controller holds its call request until acknowledged.
*/
module pvirq_core_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire pvirq_pkg::pvirq_call_t vec_call,
	input wire logic exit_cmd,
	input wire logic [1:0] ack_slow,
	output pvirq_pkg::pvirq_core_t core_ev,
	output logic vec_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_ff;
	logic [1:0] dly_ff;
	logic exit_ff;
	// ==========================================================
	// Instruction sequencing
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			phase_ff <= 2'h0;
			dly_ff <= 2'h0;
			exit_ff <= 1'b0;
			core_ev <= '0;
			vec_ack <= 1'b0;
		end
		else
		begin
			phase_ff <= phase_ff + 2'h1;
			// Exit is held until it can ride on the next start
			exit_ff <= (exit_ff | exit_cmd) & (phase_ff != 2'h3);
			core_ev.start <= (phase_ff == 2'h3);
			core_ev.is_exit <= (phase_ff == 2'h3) & (exit_ff | exit_cmd);
			// Call pushes the PC only; ack_slow stretches it for slow cores
			dly_ff <= (vec_call.req & ~vec_ack) ? dly_ff + 2'h1 : 2'h0;
			vec_ack <= vec_call.req & ~vec_ack & (dly_ff == ack_slow);
		end
	end
endmodule

/* tb/prioritized_vectored_irq_tb.sv */
/*
 Self-checking testbench of the vectored interrupt controller.
 Assumes the behavioural core model and an AXI4-Lite master made of tasks.
*/
module prioritized_vectored_irq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	pvirq_pkg::pvirq_core_t core_ev;
	pvirq_pkg::pvirq_call_t vec_call;
	logic vec_ack;
	logic ext0_pin_n = 1'b1, ext1_pin_n = 1'b1;
	logic timer0_ovf_set = 1'b0, timer1_ovf_set = 1'b0, exit_cmd = 1'b0;
	logic [1:0] ack_slow = 2'h1;
	logic [14:4] periph_req = 11'h000;
	logic ah, wh, bh, rh, seen;
	int fails = 0;
	int checks = 0;
	// Vector address of each line, in line order
	logic [15:0] vec_exp [15] = '{16'h0003, 16'h0008, 16'h0013, 16'h0018, 16'h0023,
		16'h0028, 16'h0033, 16'h0038, 16'h0043, 16'h0048,
		16'h0053, 16'h0058, 16'h0063, 16'h0068, 16'h0073};

	always #50 core_clk = ~core_clk;

	pvirq_top #(.NUM_LINES(15)) u_pvirq_top (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.core_ev, .vec_ack, .vec_call, .ext0_pin_n, .ext1_pin_n, .timer0_ovf_set,
		.timer1_ovf_set, .periph_req);
	pvirq_core_model u_pvirq_core_model (.core_clk, .rst, .vec_call, .exit_cmd, .ack_slow,
		.core_ev, .vec_ack);

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		while (!bh)
		begin
			@(negedge core_clk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			if (bh)
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge core_clk);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
			if (bh)
				s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		while (!rh)
		begin
			@(negedge core_clk);
			ah = s_axi_arvalid & s_axi_arready;
			rh = s_axi_rvalid;
			if (rh)
				chk(s_axi_rdata & m, e);
			if (rh)
				chk({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge core_clk);
			if (ah)
				s_axi_arvalid <= 1'b0;
			if (rh)
				s_axi_rready <= 1'b0;
		end
	endtask

	// Waits for a call, checks line and vector, lets the core take it
	task automatic svc(input int s);
		int n;
		n = 0;
		while (vec_call.req !== 1'b1 && n < 40)
		begin
			@(negedge core_clk);
			n++;
		end
		chk({vec_call.req, 11'h000, vec_call.src, vec_call.addr}, {1'b1, 11'h000, 4'(s),
			vec_exp[s]});
		while (vec_call.req === 1'b1)
			@(negedge core_clk);
		// Hand back on a rising edge so the caller's next drive lands there
		@(posedge core_clk);
	endtask

	task automatic idle(input int c);
		seen = 1'b0;
		repeat (c)
		begin
			@(negedge core_clk);
			seen = seen | vec_call.req;
		end
		chk({31'h0, seen}, 32'h0);
	endtask

	task automatic ex();
		@(posedge core_clk);
		exit_cmd <= 1'b1;
		@(posedge core_clk);
		exit_cmd <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 32'hFFFFFFFF, 32'h0, 2'h0);
		wr(8'h0C, 8'hA5, 2'h0);
		rd(8'h0C, 32'hFFFFFFFF, 32'hA5, 2'h0);
		wr(8'h18, 8'h55, 2'h2);
		rd(8'h18, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(8'h0C, 8'h00, 2'h0);
	endtask

	task automatic t_lines();
		wr(8'h00, 8'hF0, 2'h0);
		wr(8'h04, 8'hFF, 2'h0);
		for (int i = 4; i < 15; i++)
		begin
			periph_req[i] <= 1'b1;
			svc(i);
			periph_req[i] <= 1'b0;
			ex();
		end
		// Line 14 raised to the high level beats line 7 at low level
		wr(8'h0C, 8'h80, 2'h0);
		periph_req[14] <= 1'b1;
		periph_req[7] <= 1'b1;
		svc(14);
		periph_req[14] <= 1'b0;
		periph_req[7] <= 1'b0;
		ex();
		wr(8'h0C, 8'h00, 2'h0);
		wr(8'h04, 8'h00, 2'h0);
	endtask

	task automatic t_gate();
		wr(8'h00, 8'h70, 2'h0);
		periph_req[4] <= 1'b1;
		idle(30);
		wr(8'h00, 8'hA0, 2'h0);
		idle(30);
		wr(8'h00, 8'h90, 2'h0);
		svc(4);
		periph_req[4] <= 1'b0;
		ex();
	endtask

	task automatic t_prio();
		wr(8'h00, 8'hF0, 2'h0);
		periph_req[5:4] <= 2'h3;
		svc(4);
		idle(30);
		wr(8'h08, 8'h60, 2'h0);
		svc(5);
		periph_req[6:4] <= 3'h4;
		idle(30);
		rd(8'h14, 32'hC0, 32'hC0, 2'h0);
		ex();
		svc(6);
		periph_req[6] <= 1'b0;
		ex();
		ex();
		rd(8'h14, 32'hC0, 32'h00, 2'h0);
		periph_req[5:4] <= 2'h3;
		svc(5);
		periph_req[5:4] <= 2'h0;
		repeat (8) @(posedge core_clk);
		ex();
		wr(8'h08, 8'h00, 2'h0);
	endtask

	task automatic t_ext();
		wr(8'h10, 8'h01, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		ext0_pin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		ext0_pin_n <= 1'b1;
		rd(8'h10, 32'hFFFFFFFF, 32'h03, 2'h0);
		wr(8'h00, 8'h81, 2'h0);
		svc(0);
		rd(8'h10, 32'hFFFFFFFF, 32'h01, 2'h0);
		ex();
		wr(8'h10, 8'h00, 2'h0);
		ext0_pin_n <= 1'b0;
		svc(0);
		ex();
		svc(0);
		ext0_pin_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		ex();
		wr(8'h10, 8'h04, 2'h0);
		wr(8'h00, 8'h84, 2'h0);
		ext1_pin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		ext1_pin_n <= 1'b1;
		svc(2);
		ex();
	endtask

	task automatic t_timer();
		ack_slow <= 2'h3;
		wr(8'h00, 8'h8A, 2'h0);
		timer1_ovf_set <= 1'b1;
		@(posedge core_clk);
		timer1_ovf_set <= 1'b0;
		svc(3);
		rd(8'h10, 32'hFFFFFFFF, 32'h04, 2'h0);
		ex();
		wr(8'h10, 8'h20, 2'h0);
		svc(1);
		rd(8'h10, 32'hFFFFFFFF, 32'h00, 2'h0);
		ex();
		wr(8'h00, 8'h00, 2'h0);
		timer0_ovf_set <= 1'b1;
		@(posedge core_clk);
		timer0_ovf_set <= 1'b0;
		wr(8'h10, 8'h00, 2'h0);
		wr(8'h00, 8'h8A, 2'h0);
		idle(30);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_lines();
		t_gate();
		t_prio();
		t_ext();
		t_timer();
		print_verdict();
	end

	initial
	begin
		#2000000;
		fails++;
		print_verdict();
	end
endmodule
